/* File: src/pit_pkg.sv */
package pit_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam logic [ADDR_W-1:0] IDX_STATUS   = 12'h04B;
  localparam logic [ADDR_W-1:0] IDX_COUNT_HI = 12'h04C;
  localparam logic [ADDR_W-1:0] IDX_COUNT_LO = 12'h04D;
  localparam logic [ADDR_W-1:0] IDX_MOD_HI   = 12'h04E;
  localparam logic [ADDR_W-1:0] IDX_MOD_LO   = 12'h04F;

  localparam logic [ADDR_W-1:0] ADDR_STATUS   = IDX_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = IDX_COUNT_HI << 2;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = IDX_COUNT_LO << 2;
  localparam logic [ADDR_W-1:0] ADDR_MOD_HI   = IDX_MOD_HI << 2;
  localparam logic [ADDR_W-1:0] ADDR_MOD_LO   = IDX_MOD_LO << 2;

  // ************************************************************
  // Status/control field positions
  // ************************************************************
  localparam int unsigned BIT_OVF   = 7;
  localparam int unsigned BIT_IE    = 6;
  localparam int unsigned BIT_HALT  = 5;
  localparam int unsigned BIT_CLR   = 4;
  localparam int unsigned PRESC_LSB = 0;
  localparam int unsigned PRESC_W   = 3;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [15:0]        RST_MODULO = 16'hFFFF;
  localparam logic [PRESC_W-1:0] RST_PRESC  = 3'h0;
  localparam logic               RST_HALT   = 1'b1;
  localparam int unsigned        PRE_W      = 6;
  localparam logic [2:0]         PRESC_MAX  = 3'h6;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    PIT_SEL_NONE    = 3'b000,
    PIT_SEL_STATUS  = 3'b001,
    PIT_SEL_COUNT_H = 3'b010,
    PIT_SEL_COUNT_L = 3'b011,
    PIT_SEL_MOD_H   = 3'b100,
    PIT_SEL_MOD_L   = 3'b101
  } pit_sel_t;

  typedef struct packed {
    logic               overflow_flag;
    logic               overflow_irq_enable;
    logic               counter_halt;
    logic [PRESC_W-1:0] prescale_select;
  } pit_ctrl_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] modulo;
    logic [7:0]  low_buf;
    logic        latched;
    logic        clear_armed;
    logic        mod_inhibit;
  } pit_timer_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } pit_apb_rsp_t;

endpackage : pit_pkg

/* File: src/pit_prescaler.sv */
module pit_prescaler #(
  parameter int unsigned PRE_W = pit_pkg::PRE_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] select,
  output logic            tick
);

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic [PRE_W-1:0] mask;

  // ************************************************************
  // Tap mask for a divide by two to the power of select, select capped at PRESC_MAX
  // ************************************************************
  function automatic logic [PRE_W-1:0] tap_mask(input logic [2:0] sel);
    logic [2:0]       s;
    logic [PRE_W-1:0] m;
    s = (sel > pit_pkg::PRESC_MAX) ? pit_pkg::PRESC_MAX : sel;
    m = '0;
    for (int i = 0; i < PRE_W; i++) begin
      if (i < int'(s)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : tap_mask

  always_comb begin
    mask  = tap_mask(select);
    tick  = run && ((pre_q & mask) == mask);
    pre_d = pre_q;
    if (clear) begin
      pre_d = '0;
    end else if (run) begin
      pre_d = pre_q + PRE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (clk_en) begin
      pre_q <= pre_d;
    end
  end

endmodule : pit_prescaler

/* File: src/pit_timer.sv */
// Design decisions made here: the register addresses and the APB register port.
module pit_timer #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pit_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [pit_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [pit_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        debug_break,
  input  wire logic                        stop_mode,
  output logic                             irq
);

  // ************************************************************
  // Declarations
  // ************************************************************
  pit_pkg::pit_apb_rsp_t rsp_q;
  pit_pkg::pit_apb_rsp_t rsp_d;
  pit_pkg::pit_ctrl_t    ctrl_q;
  pit_pkg::pit_ctrl_t    ctrl_d;
  pit_pkg::pit_timer_t   tmr_q;
  pit_pkg::pit_timer_t   tmr_d;
  logic                  irq_q;
  logic                  irq_d;

  pit_pkg::pit_sel_t     sel;
  logic                  setup_ph;
  logic                  access_ph;
  logic                  rd_take;
  logic                  wr_take;
  logic [7:0]            wbyte;
  logic [7:0]            rbyte;
  logic                  run;
  logic                  tick;
  logic                  wrap;
  logic                  presc_clear;
  logic                  wr_status;
  logic                  wr_mod_h;
  logic                  wr_mod_l;
  logic                  rd_status;
  logic                  rd_count_h;
  logic                  rd_count_l;
  logic                  clr_req;
  logic                  ovf_set;

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic pit_pkg::pit_sel_t decode(input logic [pit_pkg::ADDR_W-1:0] a);
    pit_pkg::pit_sel_t s;
    if (a == pit_pkg::ADDR_STATUS) begin
      s = pit_pkg::PIT_SEL_STATUS;
    end else if (a == pit_pkg::ADDR_COUNT_HI) begin
      s = pit_pkg::PIT_SEL_COUNT_H;
    end else if (a == pit_pkg::ADDR_COUNT_LO) begin
      s = pit_pkg::PIT_SEL_COUNT_L;
    end else if (a == pit_pkg::ADDR_MOD_HI) begin
      s = pit_pkg::PIT_SEL_MOD_H;
    end else if (a == pit_pkg::ADDR_MOD_LO) begin
      s = pit_pkg::PIT_SEL_MOD_L;
    end else begin
      s = pit_pkg::PIT_SEL_NONE;
    end
    return s;
  endfunction : decode

  // ************************************************************
  // Bus phase qualifiers
  // ************************************************************
  assign sel       = decode(paddr);
  assign setup_ph  = psel && !penable && !rsp_q.pready;
  assign access_ph = psel && penable && rsp_q.pready;
  // Read side effects at setup so data and buffer agree
  assign rd_take   = setup_ph && !pwrite;
  assign wr_take   = access_ph && pwrite && pstrb[0] && (sel != pit_pkg::PIT_SEL_NONE);
  assign wbyte     = pwdata[7:0];

  // ************************************************************
  // Status byte as software sees it
  // ************************************************************
  function automatic logic [7:0] status_byte(input pit_pkg::pit_ctrl_t c);
    logic [7:0] b;
    b = 8'h00;
    b[pit_pkg::BIT_OVF]  = c.overflow_flag;
    b[pit_pkg::BIT_IE]   = c.overflow_irq_enable;
    b[pit_pkg::BIT_HALT] = c.counter_halt;
    b[pit_pkg::BIT_CLR]  = 1'b0;
    b[pit_pkg::PRESC_LSB +: pit_pkg::PRESC_W] = c.prescale_select;
    return b;
  endfunction : status_byte

  // ************************************************************
  // Read data mux
  // ************************************************************
  always_comb begin
    rbyte = 8'h00;
    if (sel == pit_pkg::PIT_SEL_STATUS) begin
      rbyte = status_byte(ctrl_q);
    end else if (sel == pit_pkg::PIT_SEL_COUNT_H) begin
      rbyte = tmr_q.count[15:8];
    end else if (sel == pit_pkg::PIT_SEL_COUNT_L) begin
      rbyte = tmr_q.latched ? tmr_q.low_buf : tmr_q.count[7:0];
    end else if (sel == pit_pkg::PIT_SEL_MOD_H) begin
      rbyte = tmr_q.modulo[15:8];
    end else if (sel == pit_pkg::PIT_SEL_MOD_L) begin
      rbyte = tmr_q.modulo[7:0];
    end
  end

  // ************************************************************
  // APB slave response, no wait state
  // ************************************************************
  always_comb begin
    rsp_d         = '0;
    rsp_d.pready  = setup_ph;
    rsp_d.pslverr = setup_ph && (sel == pit_pkg::PIT_SEL_NONE);
    if (rd_take) begin
      rsp_d.prdata = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else if (clk_en) begin
      rsp_q <= rsp_d;
    end
  end

  // ************************************************************
  // Prescaler
  // ************************************************************
  assign run = !ctrl_q.counter_halt && !debug_break && !stop_mode;
  assign presc_clear = clr_req;

  pit_prescaler #(
    .PRE_W   (pit_pkg::PRE_W)
  ) pit_prescaler_i (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (run),
    .clear   (presc_clear),
    .select  (ctrl_q.prescale_select),
    .tick    (tick)
  );

  // ************************************************************
  // Access strobes
  // ************************************************************
  assign wr_status  = wr_take && (sel == pit_pkg::PIT_SEL_STATUS);
  assign wr_mod_h   = wr_take && (sel == pit_pkg::PIT_SEL_MOD_H);
  assign wr_mod_l   = wr_take && (sel == pit_pkg::PIT_SEL_MOD_L);
  assign rd_status  = rd_take && (sel == pit_pkg::PIT_SEL_STATUS);
  assign rd_count_h = rd_take && (sel == pit_pkg::PIT_SEL_COUNT_H);
  assign rd_count_l = rd_take && (sel == pit_pkg::PIT_SEL_COUNT_L);
  assign clr_req    = wr_status && wbyte[pit_pkg::BIT_CLR];
  // Overflow that reaches the flag, masked during modulo update or clear
  assign ovf_set    = wrap && !tmr_q.mod_inhibit && !clr_req;

  // ************************************************************
  // Control and flag
  // ************************************************************
  assign wrap = tick && (tmr_q.count == tmr_q.modulo);

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_status) begin
      ctrl_d.overflow_irq_enable = wbyte[pit_pkg::BIT_IE];
      ctrl_d.counter_halt        = wbyte[pit_pkg::BIT_HALT];
      ctrl_d.prescale_select     = wbyte[pit_pkg::PRESC_LSB +: pit_pkg::PRESC_W];
      // Only a zero clears, and only after an armed read
      if (!wbyte[pit_pkg::BIT_OVF] && tmr_q.clear_armed) begin
        ctrl_d.overflow_flag = 1'b0;
      end
    end
    // Overflow event wins over a flag clear in the same cycle, unless that write also sets the clear bit
    if (ovf_set) begin
      ctrl_d.overflow_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.overflow_flag       <= 1'b0;
      ctrl_q.overflow_irq_enable <= 1'b0;
      ctrl_q.counter_halt        <= pit_pkg::RST_HALT;
      ctrl_q.prescale_select     <= pit_pkg::RST_PRESC;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  // ************************************************************
  // Counter, read buffer and modulo
  // ************************************************************
  always_comb begin
    tmr_d = tmr_q;
    // Counting
    if (tick) begin
      if (wrap) begin
        tmr_d.count = '0;
      end else begin
        tmr_d.count = tmr_q.count + 16'h0001;
      end
    end
    // Read side effects
    if (rd_status && ctrl_q.overflow_flag) begin
      tmr_d.clear_armed = 1'b1;
    end
    if (rd_count_h && !tmr_q.latched) begin
      tmr_d.low_buf = tmr_q.count[7:0];
      tmr_d.latched = 1'b1;
    end
    if (rd_count_l) begin
      tmr_d.latched = 1'b0;
    end
    // Any status write ends the clearing sequence
    if (wr_status) begin
      tmr_d.clear_armed = 1'b0;
    end
    if (clr_req) begin
      tmr_d.count   = '0;
      tmr_d.low_buf = 8'h00;
      tmr_d.latched = 1'b0;
    end
    // Modulo writes
    if (wr_mod_h) begin
      tmr_d.modulo[15:8] = wbyte;
      tmr_d.mod_inhibit  = 1'b1;
    end
    if (wr_mod_l) begin
      tmr_d.modulo[7:0]  = wbyte;
      tmr_d.mod_inhibit  = 1'b0;
    end
    // Overflow voids an armed clear
    if (ovf_set) begin
      tmr_d.clear_armed = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q.count       <= '0;
      tmr_q.modulo      <= pit_pkg::RST_MODULO;
      tmr_q.low_buf     <= 8'h00;
      tmr_q.latched     <= 1'b0;
      tmr_q.clear_armed <= 1'b0;
      tmr_q.mod_inhibit <= 1'b0;
    end else if (clk_en) begin
      tmr_q <= tmr_d;
    end
  end

  // ************************************************************
  // Interrupt request
  // ************************************************************
  always_comb begin
    irq_d = ctrl_d.overflow_flag && ctrl_d.overflow_irq_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= irq_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata  = rsp_q.prdata;
  assign pready  = rsp_q.pready;
  assign pslverr = rsp_q.pslverr;
  assign irq     = irq_q;

endmodule : pit_timer

/* File: tb/pit_timer_properties.sv */
module pit_timer_properties #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        debug_break,
  input wire logic        stop_mode,
  input wire logic        irq
);
  logic mapped;
  logic st_at;
  assign mapped = paddr inside {pit_pkg::ADDR_STATUS, pit_pkg::ADDR_COUNT_HI,
                                pit_pkg::ADDR_COUNT_LO, pit_pkg::ADDR_MOD_HI, pit_pkg::ADDR_MOD_LO};
  assign st_at = paddr == pit_pkg::ADDR_STATUS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable && clk_en; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
  property p_idle; !pready |-> prdata == 32'h0000_0000 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("bus outputs active outside access");
  property p_unmap; s_done ##0 !mapped |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_map; s_done ##0 mapped |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  property p_rsv; s_done ##0 (!pwrite && st_at) |-> prdata[31:8] == 24'h0 && prdata[4:3] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("status clear or reserved bit reads one");
  property p_irq_and; s_done ##0 (!pwrite && st_at) |-> $past(irq) == (prdata[7] && prdata[6]); endproperty
  a_irq_and: assert property (p_irq_and) else $error("irq differs from flag and enable");
  property p_irq_off;
    s_done ##0 (pwrite && st_at && pstrb[0] && !pwdata[pit_pkg::BIT_IE]) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with enable cleared");
  property p_irq_fall; $fell(irq) |-> $past(psel && penable && pready && pwrite && st_at); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without status write");
  property p_freeze; !clk_en && !pready |=> !pready; endproperty
  a_freeze: assert property (p_freeze) else $error("ready while clock enable low");
endmodule : pit_timer_properties

bind pit_timer pit_timer_properties #(.CNT_W(CNT_W)) pit_timer_properties_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .debug_break(debug_break), .stop_mode(stop_mode),
  .irq(irq));

/* File: tb/pit_timer_tb.sv */
module pit_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_ST = pit_pkg::ADDR_STATUS;
  localparam logic [11:0] A_CH = pit_pkg::ADDR_COUNT_HI;
  localparam logic [11:0] A_CL = pit_pkg::ADDR_COUNT_LO;
  localparam logic [11:0] A_MH = pit_pkg::ADDR_MOD_HI;
  localparam logic [11:0] A_ML = pit_pkg::ADDR_MOD_LO;
  localparam logic [33:0] M_D  = 34'h1_FFFF_FFFF;
  typedef struct {logic [33:0] e; logic [33:0] m; int tol;} pit_exp_t;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        debug_break, stop_mode, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  pit_exp_t    q[$];
  int          miscompares = 0;
  int          n_checks = 0;
  int          seed = 78;
  int          r;
  int          x;

  pit_timer pit_timer_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_break(debug_break),
    .stop_mode(stop_mode), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // ************************************************************
  // Bus driver, expectations queued in call order
  // ************************************************************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [33:0] e, input logic [33:0] m, input int tol);
    pit_exp_t t;
    t = '{e, m, tol};
    q.push_back(t);
    @(posedge pclk);
    r = $random(seed);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {r[23:0], d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 34'h0, 34'h1_0000_0000, 0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] v, input int tol);
    xfer(1'b0, a, 8'h00, {26'h0, v}, M_D, tol);
  endtask : rd

  task automatic rs(input logic [7:0] v, input logic i);
    xfer(1'b0, A_ST, 8'h00, {i, 25'h0, v}, 34'h3_FFFF_FFFF, 0);
  endtask : rs

  task automatic wait_irq;
    x = 0;
    while (irq !== 1'b1 && x < 200) begin
      @(posedge pclk);
      x++;
    end
  endtask : wait_irq

  always @(posedge pclk) begin
    pit_exp_t    t;
    logic [33:0] s;
    int          df;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      t = q.pop_front();
      s = {irq, pslverr, prdata} & t.m;
      df = int'(prdata[7:0]) - int'(t.e[7:0]);
      if (t.tol > 0 && !$isunknown(prdata[7:0]) && df <= t.tol && df >= -t.tol) begin
        s[7:0] = t.e[7:0];
      end
      check(s, t.e);
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end

  initial begin
    presetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF; debug_break = 1'b0; stop_mode = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rs(8'h20, 1'b0);
    rd(A_CH, 8'h00, 0);
    rd(A_CL, 8'h00, 0);
    rd(A_MH, 8'hFF, 0);
    rd(A_ML, 8'hFF, 0);
    pstrb <= 4'hE;
    wr(A_MH, 8'h00);
    pstrb <= 4'hF;
    rd(A_MH, 8'hFF, 0);
    r = $random(seed);
    xfer(1'b0, {3'h1, r[6:0], 2'h0}, 8'h00, 34'h1_0000_0000, M_D, 0);
    $display("reset and map test done");
    for (int s = 0; s < 8; s++) begin
      int d;
      d = (s == 7) ? 6 : s;
      wr(A_ST, 8'h30);
      rd(A_CL, 8'h00, 0);
      wr(A_ST, 8'(s));
      repeat (252) @(posedge pclk);
      wr(A_ST, 8'h20 | 8'(s));
      rd(A_CH, 8'h00, 0);
      rd(A_CL, 8'((255 + (1 << d) / 2) >> d), (s == 0) ? 2 : 1);
    end
    $display("prescale test done");
    rd(A_CH, 8'h00, 0);
    wr(A_ST, 8'h00);
    repeat (40) @(posedge pclk);
    rd(A_CH, 8'h00, 0);
    rd(A_CL, 8'h04, 1);
    wr(A_ST, 8'h30);
    rs(8'h20, 1'b0);
    rd(A_CH, 8'h00, 0);
    rd(A_CL, 8'h00, 0);
    rd(A_ML, 8'hFF, 0);
    $display("latch and clear test done");
    debug_break <= 1'b1;
    wr(A_ST, 8'h00);
    repeat (20) @(posedge pclk);
    rd(A_CL, 8'h00, 0);
    debug_break <= 1'b0;
    stop_mode   <= 1'b1;
    repeat (20) @(posedge pclk);
    rd(A_CL, 8'h00, 0);
    stop_mode <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(A_CL, 8'd21, 2);
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    rd(A_CL, 8'd24, 1);
    $display("hold test done");
    wr(A_ST, 8'h30);
    wr(A_MH, 8'h00);
    wr(A_ML, 8'h01);
    wr(A_ST, 8'h40);
    wait_irq();
    rs(8'hC0, 1'b1);
    wr(A_ST, 8'h60);
    rs(8'hE0, 1'b1);
    wr(A_ST, 8'hE0);
    wr(A_ST, 8'h60);
    rs(8'hE0, 1'b1);
    wr(A_ST, 8'h60);
    rs(8'h60, 1'b0);
    $display("flag test done");
    wr(A_ST, 8'h30);
    wr(A_MH, 8'h00);
    wr(A_ST, 8'h40);
    repeat (20) @(posedge pclk);
    rs(8'h40, 1'b0);
    wr(A_ML, 8'h01);
    wait_irq();
    rs(8'hC0, 1'b1);
    $display("modulo inhibit test done");
    test_done();
  end
endmodule : pit_timer_tb
